// >>> core/sfc_device.sv
// Flash device end: decodes control commands on the SPI link and tracks write state
`timescale 1ns/10ps
`include "sfc_consts.svh"
module sfc_device #(
    parameter logic [7:0] MAKER_CODE = 8'h5A,  // Arbitrary identity value
    parameter logic [7:0] TYPE_CODE  = 8'h3C,  // Arbitrary identity value
    parameter logic [7:0] CAP_CODE   = 8'h0F,  // Arbitrary identity value
    parameter logic [7:0] DEV_CODE   = 8'hC3,  // Arbitrary identity value
    parameter int         WRITE_CYC  = `SFC_WRITE_US * `SFC_CLK_MHZ,
    parameter int         PAUSE_CYC  = `SFC_PAUSE_REC_US * `SFC_CLK_MHZ,
    parameter int         RESET_CYC  = `SFC_RST_SETTLE_US * `SFC_CLK_MHZ
) (
    input  wire logic CLK,
    input  wire logic RESETN,
    input  wire logic CE,
    sfc_link_if.device LINK,
    output logic      NOT_READY,
    output logic      PAUSED,
    output logic      DEEP_SLEEP,
    output logic      RESET_ARMED,
    output logic      ARRAY_CORRUPT
);
    // Link domain: SCK clocks the shift logic, frames bounded by chip select
    logic [5:0]  bit_cnt_reg;
    logic [7:0]  op_reg;
    logic        op_done_reg;
    logic [31:0] out_sr_reg;
    logic        so_reg;
    logic        so_en_reg;
    logic [7:0]  frame_op_reg;
    logic [5:0]  frame_bits_reg;
    logic        fire_reg;
    logic        cmd_edge;
    logic [31:0] rec_cnt_reg;
    logic        id_ok_reg;
    logic [7:0]  op_next;
    logic [2:0]  sync_reg;
    logic [7:0]  cmd_op_reg;
    logic [5:0]  cmd_bits_reg;
    logic        cmd_fire;
    logic        link_busy_s1_reg;
    logic        link_busy_reg;
    logic        refuse_id;

    // Status as seen by the link: write or recovery in progress refuses ID reads
    assign refuse_id = NOT_READY;

    assign op_next = {op_reg[6:0], LINK.si};

    // Rising SCK: sample SI, MSB first; frame state clears while deselected
    always_ff @(posedge LINK.sck or posedge LINK.cs_n) begin
        if (LINK.cs_n) begin
            bit_cnt_reg <= 6'h00;
            op_reg      <= 8'h00;
            op_done_reg <= 1'b0;
        end else begin
            if (bit_cnt_reg != 6'h3F) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
            if (!op_done_reg) begin
                op_reg <= op_next;
            end
            if (bit_cnt_reg == 6'h07) begin
                op_done_reg <= 1'b1;
            end
        end
    end

    // Two-flop crossing of the busy level into the link domain (sampled on SCK)
    always_ff @(posedge LINK.sck) begin
        link_busy_s1_reg <= refuse_id | DEEP_SLEEP;
        link_busy_reg    <= link_busy_s1_reg;
    end

    // Latch whether an ID read is allowed when the opcode completes
    always_ff @(posedge LINK.sck) begin
        if (bit_cnt_reg == 6'h07) begin
            id_ok_reg <= !link_busy_reg;
        end
    end

    // Falling SCK: shift ID bytes out, repeating the pattern while clocks run
    always_ff @(negedge LINK.sck or posedge LINK.cs_n) begin
        if (LINK.cs_n) begin
            out_sr_reg <= 32'h0000_0000;
            so_reg     <= 1'b0;
            so_en_reg  <= 1'b0;  // Output floats while deselected
        end else if (op_done_reg && id_ok_reg && op_reg == `SFC_OP_STD_ID) begin
            if (!so_en_reg || out_sr_reg == 32'h8000_0000) begin
                out_sr_reg <= {MAKER_CODE[6:0], TYPE_CODE, CAP_CODE, 8'h00, 1'b1};
                so_reg     <= MAKER_CODE[7];
                so_en_reg  <= 1'b1;
            end else begin
                so_reg     <= out_sr_reg[31];
                out_sr_reg <= {out_sr_reg[30:0], 1'b0};
            end
        end else if (op_done_reg && id_ok_reg && op_reg == `SFC_OP_DEV_ID
                     && bit_cnt_reg >= 6'd32) begin
            if (!so_en_reg) begin
                out_sr_reg <= {DEV_CODE, 24'h00_0000};
                so_reg     <= DEV_CODE[7];
                so_en_reg  <= 1'b1;
            end else begin
                so_reg <= out_sr_reg[30];
                out_sr_reg <= {out_sr_reg[30:24], out_sr_reg[31], 24'h00_0000};
            end
        end
    end

    // A marker bit trails the pattern; once it alone is left the pattern restarts
    assign LINK.so_out  = so_reg;
    assign LINK.so_oe_n = !so_en_reg;

    // Frame end: record opcode and bit count for the core
    always_ff @(posedge LINK.cs_n) begin
        frame_op_reg   <= op_reg;
        frame_bits_reg <= bit_cnt_reg;
    end

    // Core domain: cs_n passes two flops, a third finds its rising edge
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sync_reg <= 3'b111;  // Idle level, so no false frame end after reset
        end else if (CE) begin
            sync_reg <= {sync_reg[1:0], LINK.cs_n};
        end
    end
    assign cmd_edge = sync_reg[1] && !sync_reg[2];

    // Frame words settled at cs_n rise, two clocks before the edge is seen
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cmd_op_reg   <= 8'h00;
            cmd_bits_reg <= 6'h00;
            fire_reg     <= 1'b0;
        end else if (CE) begin
            fire_reg <= cmd_edge;
            if (cmd_edge) begin
                cmd_op_reg   <= frame_op_reg;
                cmd_bits_reg <= frame_bits_reg;
            end
        end
    end
    assign cmd_fire = CE && fire_reg;

    // Decode of write-starting opcodes, used for start and cancel
    function automatic logic is_write(input logic [7:0] op);
        is_write = (op == `SFC_OP_SSE_A) || (op == `SFC_OP_SSE_B) || (op == `SFC_OP_LSE)
                || (op == `SFC_OP_CHE_A) || (op == `SFC_OP_CHE_B)
                || (op == `SFC_OP_PGW) || (op == `SFC_OP_PGW_LP);
    endfunction

    // Commands allowed while paused
    function automatic logic pause_ok(input logic [7:0] op);
        pause_ok = (op == `SFC_OP_STATUS) || (op == `SFC_OP_READ)
                || (op == `SFC_OP_READ_FAST) || (op == `SFC_OP_READ_DUAL)
                || (op == `SFC_OP_READ_DIO) || (op == `SFC_OP_RELEASE) || is_write(op)
                || (op == `SFC_OP_RST_ARM) || (op == `SFC_OP_RST_EXEC); // Reset ends pause
    endfunction

    sfc_pkg::sfc_write_type wr_state_reg;
    logic [31:0] timer_reg;
    logic        full_byte;
    logic        accept;
    logic        rst_exec;

    assign full_byte = (cmd_bits_reg >= 6'd8);
    // Recovering or asleep frames are dropped, busy ones pass; sleep admits only exit
    assign accept = cmd_fire && full_byte && !(NOT_READY && wr_state_reg != sfc_pkg::SFC_BUSY)
                 && (!DEEP_SLEEP || cmd_op_reg == `SFC_OP_DEV_ID)
                 && (wr_state_reg != sfc_pkg::SFC_PAUSED || pause_ok(cmd_op_reg));
    assign rst_exec = accept && RESET_ARMED && cmd_op_reg == `SFC_OP_RST_EXEC;

    // Reset arm: set by arm frame, any other accepted frame disarms
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            RESET_ARMED <= 1'b0;
        end else if (accept) begin
            RESET_ARMED <= (cmd_op_reg == `SFC_OP_RST_ARM);
        end
    end

    // Deep sleep entry refused while writing; exit by the wake opcode
    always_ff @(posedge CLK) begin
        if (!RESETN || rst_exec) begin
            DEEP_SLEEP <= 1'b0;
        end else if (accept && cmd_op_reg == `SFC_OP_SLEEP && !NOT_READY && cmd_bits_reg == 6'd8
                     && wr_state_reg == sfc_pkg::SFC_IDLE) begin
            DEEP_SLEEP <= 1'b1;
        end else if (accept && DEEP_SLEEP) begin
            DEEP_SLEEP <= 1'b0;
        end
    end

    // Write state machine with pause, release, cancel and reset abort
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            wr_state_reg  <= sfc_pkg::SFC_IDLE;
            timer_reg     <= 32'h0000_0000;
            NOT_READY     <= 1'b0;
            ARRAY_CORRUPT <= 1'b0;
        end else if (rst_exec) begin
            // Abort write, clear paused and busy, settle before standby
            ARRAY_CORRUPT <= (wr_state_reg != sfc_pkg::SFC_IDLE);
            wr_state_reg  <= sfc_pkg::SFC_IDLE;
            timer_reg     <= RESET_CYC[31:0];
            NOT_READY     <= 1'b1;
        end else if (CE) begin
            case (wr_state_reg)
                sfc_pkg::SFC_IDLE: begin
                    if (accept && is_write(cmd_op_reg) && !NOT_READY) begin
                        wr_state_reg <= sfc_pkg::SFC_BUSY;
                        timer_reg    <= WRITE_CYC[31:0];
                        NOT_READY    <= 1'b1;
                    end else if (timer_reg != 32'h0000_0000) begin
                        timer_reg <= timer_reg - 32'h0000_0001;
                    end else begin
                        NOT_READY <= 1'b0;
                    end
                end
                sfc_pkg::SFC_BUSY: begin
                    if (accept && cmd_op_reg == `SFC_OP_PAUSE) begin
                        wr_state_reg <= sfc_pkg::SFC_PAUSED;
                    end else if (timer_reg == 32'h0000_0000) begin
                        wr_state_reg <= sfc_pkg::SFC_IDLE;
                        NOT_READY    <= 1'b0;
                    end else begin
                        timer_reg <= timer_reg - 32'h0000_0001;
                    end
                end
                sfc_pkg::SFC_PAUSED: begin
                    // Write timer kept; a separate count holds recovery
                    if (NOT_READY && rec_cnt_reg == 32'h0000_0000) begin
                        NOT_READY <= 1'b0;
                    end else if (accept && cmd_op_reg == `SFC_OP_RELEASE) begin
                        wr_state_reg <= sfc_pkg::SFC_BUSY;
                        NOT_READY    <= 1'b1;
                    end else if (accept && is_write(cmd_op_reg)) begin
                        wr_state_reg <= sfc_pkg::SFC_BUSY;
                        timer_reg    <= WRITE_CYC[31:0];
                        NOT_READY    <= 1'b1;
                    end
                end
                default: wr_state_reg <= sfc_pkg::SFC_IDLE;
            endcase
        end
    end

    // Pause recovery counter, loaded when a pause is taken
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rec_cnt_reg <= 32'h0000_0000;
        end else if (CE) begin
            if (wr_state_reg == sfc_pkg::SFC_BUSY && accept && cmd_op_reg == `SFC_OP_PAUSE) begin
                rec_cnt_reg <= PAUSE_CYC[31:0];
            end else if (rec_cnt_reg != 32'h0000_0000) begin
                rec_cnt_reg <= rec_cnt_reg - 32'h0000_0001;
            end
        end
    end

    assign PAUSED = (wr_state_reg == sfc_pkg::SFC_PAUSED);
endmodule

// >>> core/sfc_consts.svh
// Opcodes, identification values and timing counts for the flash control command block
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
`define SFC_OP_PAUSE        8'hB0
`define SFC_OP_RELEASE      8'h30
`define SFC_OP_STD_ID       8'h9F
`define SFC_OP_DEV_ID       8'hAB
`define SFC_OP_SLEEP        8'hB9
`define SFC_OP_RST_ARM      8'h66
`define SFC_OP_RST_EXEC     8'h99
`define SFC_OP_SSE_A        8'h20
`define SFC_OP_SSE_B        8'hD7
`define SFC_OP_LSE          8'hD8
`define SFC_OP_CHE_A        8'h60
`define SFC_OP_CHE_B        8'hC7
`define SFC_OP_PGW          8'h02
`define SFC_OP_PGW_LP       8'h0A
`define SFC_OP_STATUS       8'h05
`define SFC_OP_READ         8'h03
`define SFC_OP_READ_FAST    8'h0B
`define SFC_OP_READ_DUAL    8'h3B
`define SFC_OP_READ_DIO     8'hBB
`define SFC_STD_ID_BITS     32
`define SFC_DEV_ID_DUMMY    32
// Pause recovery, reset settle and write busy time, in us
`define SFC_PAUSE_REC_US    20
`define SFC_RST_SETTLE_US   40
`define SFC_WRITE_US        400
`define SFC_CLK_MHZ         100
`define SFC_DIV_HALF        4
`endif

// >>> core/sfc_pkg.sv
// Types used by the device end of the flash control command link
package sfc_pkg;
    typedef enum logic [1:0] {
        SFC_IDLE,
        SFC_BUSY,
        SFC_PAUSED
    } sfc_write_type;
endpackage

// >>> core/sfc_link_if.sv
// SPI link between the host end and the flash device end
`timescale 1ns/10ps
interface sfc_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so_out;
    logic so_oe_n;
    modport device (input cs_n, input sck, input si, output so_out, output so_oe_n);
    modport host (output cs_n, output sck, output si, input so_out, input so_oe_n);
endinterface

// >>> core/sfc_host.sv
// Host end: frames one command byte plus optional dummy and read bytes on the SPI link
`timescale 1ns/10ps
`include "sfc_consts.svh"
module sfc_host #(
    parameter int MAX_BYTES = 8
) (
    input  wire logic       CLK,
    input  wire logic       RESETN,
    input  wire logic       CE,
    sfc_link_if.host        LINK,
    input  wire logic       START,
    input  wire logic [7:0] OPCODE,
    input  wire logic [3:0] NUM_BYTES,
    output logic            BUSY,
    output logic            RD_VALID,
    output logic [7:0]      RD_DATA
);
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} sfc_host_state_type;
    sfc_host_state_type st_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [3:0] bytes_reg;
    logic [2:0] bit_reg;
    logic [3:0] div_reg;
    logic       so_s1_reg;
    logic       so_s2_reg;
    logic       tick;

    // SCK is divided from CLK, so the host has a single domain
    assign tick = CE && (div_reg == 4'(`SFC_DIV_HALF - 1));
    assign BUSY = (st_reg != H_IDLE);

    always_ff @(posedge CLK) begin
        if (!RESETN || !BUSY) begin
            div_reg <= 4'h0;
        end else if (CE) begin
            div_reg <= tick ? 4'h0 : div_reg + 4'h1;
        end
    end

    // SO passes two flops before use
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            so_s1_reg <= 1'b0;
            so_s2_reg <= 1'b0;
        end else if (CE) begin
            so_s1_reg <= LINK.so_out;
            so_s2_reg <= so_s1_reg;
        end
    end

    // Mode 0 framing: MSB first, change on falling, device samples on rising
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st_reg    <= H_IDLE;
            LINK.cs_n <= 1'b1;
            LINK.sck  <= 1'b0;
            LINK.si   <= 1'b0;
            tx_reg    <= 8'h00;
            rx_reg    <= 8'h00;
            bytes_reg <= 4'h0;
            bit_reg   <= 3'h0;
            RD_VALID  <= 1'b0;
            RD_DATA   <= 8'h00;
        end else if (CE) begin
            RD_VALID <= 1'b0;
            case (st_reg)
                H_IDLE: begin
                    if (START) begin
                        // One opcode per frame; reset needs two frames
                        LINK.cs_n <= 1'b0;
                        LINK.si   <= OPCODE[7];
                        tx_reg    <= {OPCODE[6:0], 1'b0};
                        bytes_reg <= NUM_BYTES;
                        bit_reg   <= 3'h0;
                        st_reg    <= H_LOW;
                    end
                end
                H_LOW: if (tick) begin
                    LINK.sck <= 1'b1;
                    rx_reg   <= {rx_reg[6:0], so_s2_reg};
                    st_reg   <= H_HIGH;
                end
                H_HIGH: if (tick) begin
                    LINK.sck <= 1'b0;
                    LINK.si  <= tx_reg[7];  // Dummy bytes shift zeros
                    tx_reg   <= {tx_reg[6:0], 1'b0};
                    bit_reg  <= bit_reg + 3'h1;
                    st_reg   <= H_LOW;
                    if (bit_reg == 3'h7) begin
                        RD_VALID <= 1'b1;
                        RD_DATA  <= rx_reg;
                        if (bytes_reg == 4'h0) begin
                            st_reg <= H_END;
                        end else begin
                            bytes_reg <= bytes_reg - 4'h1;
                        end
                    end
                end
                H_END: if (tick) begin
                    LINK.cs_n <= 1'b1;  // Rising edge executes command
                    st_reg    <= H_IDLE;
                end
                default: st_reg <= H_IDLE;
            endcase
        end
    end
endmodule

// >>> verif/sfc_link_properties.sv
// Link and status assertions for the flash control command block
`timescale 1ns/10ps
module sfc_link_properties (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic so_oe_n,
    input wire logic NOT_READY,
    input wire logic PAUSED,
    input wire logic DEEP_SLEEP,
    input wire logic RESET_ARMED
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    // A settled gap between frames; the device resyncs cs_n, so allow a few cycles
    sequence s_idle;
        cs_n[*4];
    endsequence
    // State changes are only legal once the frame has closed
    sequence s_closed;
        cs_n;
    endsequence

    property p_idle_float;
        s_idle |-> so_oe_n;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("output driven while deselected");

    property p_release_float;
        $rose(cs_n) |-> ##[0:5] so_oe_n;
    endproperty
    a_release_float: assert property (p_release_float) else $error("output not released");

    property p_idle_sck;
        s_idle |-> !sck;
    endproperty
    a_idle_sck: assert property (p_idle_sck) else $error("serial clock not idle low");

    property p_pause_entry;
        $rose(PAUSED) |-> s_closed and ($past(NOT_READY) && !$past(DEEP_SLEEP));
    endproperty
    a_pause_entry: assert property (p_pause_entry) else $error("pause without write");

    property p_sleep_entry;
        $rose(DEEP_SLEEP) |-> s_closed and (!$past(NOT_READY) && !$past(PAUSED));
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered when busy");

    property p_sleep_exit;
        $fell(DEEP_SLEEP) |-> s_closed;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep left mid frame");

    property p_pause_end;
        $fell(PAUSED) |-> s_closed;
    endproperty
    a_pause_end: assert property (p_pause_end) else $error("pause left mid frame");

    property p_arm_frame;
        $changed(RESET_ARMED) |-> s_closed;
    endproperty
    a_arm_frame: assert property (p_arm_frame) else $error("reset arm moved mid frame");

    property p_sleep_deaf;
        DEEP_SLEEP && $past(DEEP_SLEEP) |-> !$rose(NOT_READY) && !$rose(RESET_ARMED);
    endproperty
    a_sleep_deaf: assert property (p_sleep_deaf) else $error("command taken in sleep");
endmodule

// >>> verif/spi_flash_suspend_id_power_reset_tb_top.sv
// Testbench joining host and device ends over the SPI link
`timescale 1ns/10ps
module spi_flash_suspend_id_power_reset_tb_top;
    localparam logic [7:0] MK = 8'h5A;  // Arbitrary identity value
    localparam logic [7:0] TY = 8'h3C;  // Arbitrary identity value
    localparam logic [7:0] CP = 8'h0F;  // Arbitrary identity value
    localparam logic [7:0] DV = 8'hC3;  // Arbitrary identity value
    logic       CLK;
    logic       RESETN;
    logic       CE;
    logic       START;
    logic [7:0] OPCODE;
    logic [3:0] NUM_BYTES;
    logic       BUSY;
    logic       RD_VALID;
    logic [7:0] RD_DATA;
    logic       NOT_READY;
    logic       PAUSED;
    logic       DEEP_SLEEP;
    logic       RESET_ARMED;
    logic       ARRAY_CORRUPT;
    logic [7:0] rq[$];
    logic [7:0] id[4];
    logic       oe_on;
    int         errors;
    int         n_tests;

    sfc_link_if link ();
    sfc_device #(.MAKER_CODE(MK), .TYPE_CODE(TY), .CAP_CODE(CP), .DEV_CODE(DV),
        .WRITE_CYC(2000), .PAUSE_CYC(20), .RESET_CYC(20)) u_sfc_device (
        .CLK(CLK), .RESETN(RESETN), .CE(CE), .LINK(link.device),
        .NOT_READY(NOT_READY), .PAUSED(PAUSED), .DEEP_SLEEP(DEEP_SLEEP),
        .RESET_ARMED(RESET_ARMED), .ARRAY_CORRUPT(ARRAY_CORRUPT));
    sfc_host #(.MAX_BYTES(8)) u_sfc_host (
        .CLK(CLK), .RESETN(RESETN), .CE(CE), .LINK(link.host), .START(START),
        .OPCODE(OPCODE), .NUM_BYTES(NUM_BYTES), .BUSY(BUSY), .RD_VALID(RD_VALID),
        .RD_DATA(RD_DATA));
    sfc_link_properties u_sfc_link_properties (
        .CLK(CLK), .RESETN(RESETN), .cs_n(link.cs_n), .sck(link.sck),
        .so_oe_n(link.so_oe_n), .NOT_READY(NOT_READY), .PAUSED(PAUSED),
        .DEEP_SLEEP(DEEP_SLEEP), .RESET_ARMED(RESET_ARMED));

    // Free running core clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // Collect received bytes and note any time the device drives its output
    always @(posedge CLK) begin
        if (RD_VALID === 1'b1) rq.push_back(RD_DATA);
        if (link.so_oe_n === 1'b0) oe_on = 1'b1;
    end

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // One host frame; waits on BUSY with a bound, then lets the device act on cs_n rise
    task automatic send(input logic [7:0] op, input logic [3:0] n);
        int i;
        rq.delete();
        oe_on = 1'b0;
        @(negedge CLK);
        START = 1'b1;
        OPCODE = op;
        NUM_BYTES = n;
        @(negedge CLK);
        START = 1'b0;
        i = 0;
        while (BUSY !== 1'b0 && i < 3000) begin
            @(negedge CLK);
            i++;
        end
        if (i >= 3000) chk(8'h01, 8'h00, "host hung");
        repeat (8) @(negedge CLK);
    endtask

    // Bounded wait for the write or settle time to run out
    task automatic wait_ready;
        int i;
        i = 0;
        while (NOT_READY !== 1'b0 && i < 6000) begin
            @(negedge CLK);
            i++;
        end
        chk({7'h00, NOT_READY}, 8'h00, "never ready");
    endtask

    task automatic pause_write;
        send(8'h02, 4'h4);
        chk({7'h00, NOT_READY}, 8'h01, "write not busy");
        send(8'hB0, 4'h0);
        chk({7'h00, PAUSED}, 8'h01, "not paused");
        repeat (60) @(negedge CLK);
    endtask

    initial begin
        #600000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        errors = 0;
        n_tests = 0;
        RESETN = 1'b0;
        CE = 1'b1;
        START = 1'b0;
        OPCODE = 8'h00;
        NUM_BYTES = 4'h0;
        oe_on = 1'b0;
        id = '{MK, TY, CP, 8'h00};
        repeat (5) @(negedge CLK);
        RESETN = 1'b1;
        repeat (2) @(negedge CLK);
        chk({3'h0, NOT_READY, PAUSED, DEEP_SLEEP, RESET_ARMED, ARRAY_CORRUPT}, 8'h00, "reset");
        // Two passes of the four byte code, then the device code after dummies
        send(8'h9F, 4'h8);
        chk(rq.size() >= 8 ? 8'h01 : 8'h00, 8'h01, "std id count");
        for (int k = 0; k < 8; k++) chk(rq[rq.size() - 8 + k], id[k % 4], "std id");
        send(8'hAB, 4'h5);
        for (int k = 1; k <= 2; k++) chk(rq[rq.size() - k], DV, "dev id");
        // Sleep ignores all but exit; both exit forms wake the device
        send(8'hB9, 4'h0);
        chk({7'h00, DEEP_SLEEP}, 8'h01, "no sleep");
        send(8'h02, 4'h4);
        chk({7'h00, NOT_READY}, 8'h00, "write in sleep");
        send(8'hAB, 4'h0);
        chk({7'h00, DEEP_SLEEP}, 8'h00, "exit failed");
        send(8'hB9, 4'h0);
        send(8'hAB, 4'h5);
        chk({7'h00, DEEP_SLEEP}, 8'h00, "id exit failed");
        send(8'hB0, 4'h0);
        chk({7'h00, PAUSED}, 8'h00, "idle pause");
        // Busy write refuses ID reads and sleep; pause, sleep refused while paused, release
        send(8'h02, 4'h4);
        send(8'h9F, 4'h4);
        chk({7'h00, oe_on}, 8'h00, "id during write");
        send(8'hB9, 4'h0);
        chk({7'h00, DEEP_SLEEP}, 8'h00, "sleep during write");
        send(8'hB0, 4'h0);
        chk({7'h00, PAUSED}, 8'h01, "not paused");
        repeat (60) @(negedge CLK);
        chk({7'h00, NOT_READY}, 8'h00, "pause not recovered");
        send(8'hB9, 4'h0);
        chk({7'h00, DEEP_SLEEP}, 8'h00, "sleep while paused");
        send(8'h30, 4'h0);
        chk({6'h00, PAUSED, NOT_READY}, 8'h01, "resume");
        wait_ready();
        // New write cancels the pause, release is then ignored
        pause_write();
        send(8'h02, 4'h4);
        chk({6'h00, PAUSED, NOT_READY}, 8'h01, "cancel");
        wait_ready();
        send(8'h30, 4'h0);
        chk({7'h00, NOT_READY}, 8'h00, "stale resume");
        // Arm broken by another command, then a reset during pause
        send(8'h02, 4'h4);
        send(8'h66, 4'h0);
        chk({7'h00, RESET_ARMED}, 8'h01, "not armed");
        send(8'h05, 4'h1);
        send(8'h99, 4'h0);
        chk({6'h00, ARRAY_CORRUPT, NOT_READY}, 8'h01, "cancelled arm acted");
        wait_ready();
        pause_write();
        send(8'h66, 4'h0);
        send(8'h99, 4'h0);
        chk({6'h00, PAUSED, RESET_ARMED}, 8'h00, "reset in pause");
        wait_ready();
        send(8'h30, 4'h0);
        chk({7'h00, NOT_READY}, 8'h00, "resume after reset");
        // Reset during a running write aborts it and marks the array
        send(8'h02, 4'h4);
        send(8'h66, 4'h0);
        send(8'h99, 4'h0);
        chk({7'h00, ARRAY_CORRUPT}, 8'h01, "no corrupt mark");
        wait_ready();
        // Clock enable low freezes a running write past its write time
        send(8'h02, 4'h4);
        CE = 1'b0;
        repeat (3000) @(negedge CLK);
        chk({7'h00, NOT_READY}, 8'h01, "write ran while frozen");
        CE = 1'b1;
        wait_ready();
        wrap_up();
    end
endmodule
